// >>> core/pixel_port_blank_sync_latch.sv
// Pixel input port: capture, colour mode and overlay selection, blanking and sync.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "pixel_port_map.svh"

module pixel_port_blank_sync_latch
    import pixel_port_pkg::*;
#(
    parameter logic [7:0] MODE_MAP = `PP_MODE_MAP_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] red_pixel_in,
    input wire logic [7:0] green_pixel_in,
    input wire logic [7:0] blue_pixel_in,
    input wire logic [1:0] colour_mode_sel,
    input wire logic [3:0] overlay_sel,
    input wire logic blank_n,
    input wire logic sync_n,
    input wire logic pix_valid,
    output logic pix_ready,
    output logic dac_valid,
    input wire logic dac_ready,
    output logic [7:0] dac_red,
    output logic [7:0] dac_green,
    output logic [7:0] dac_blue,
    output logic dac_blank_n,
    output logic sync_current_en,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    typedef struct packed {
        logic lin_en;
        logic [7:0] pal_addr;
        logic [3:0] ovl_index;
        pix_stage_t s1;
        pix_stage_t s2;
        dac_word_t s2_word;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [`PP_ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t q, d;

    logic [23:0] pal_mem [`PP_PAL_DEPTH];
    logic [23:0] ovl_mem [`PP_OVL_DEPTH];
    logic pal_we;
    logic ovl_we;
    logic [23:0] mem_wdata;
    logic advance;
    logic [1:0] buf_level;
    dac_word_t out_word;

    pix_stream_if #(.W(DAC_WORD_W)) to_buf ();
    pix_stream_if #(.W(DAC_WORD_W)) from_buf ();

    // Maps a two-bit mode code through the mapping parameter.
    function automatic colour_mode_t decode_mode(input logic [1:0] code);
        logic [1:0] idx;
        idx = MODE_MAP[{code, 1'b0} +: 2];
        case (idx)
            2'h0: decode_mode = MODE_TRUE24;
            2'h1: decode_mode = MODE_TRUE15;
            2'h2: decode_mode = MODE_TRUE8;
            2'h3: decode_mode = MODE_PSEUDO8;
            default: decode_mode = MODE_TRUE24;
        endcase
    endfunction

    // Merges a bus write into a register under its byte strobes.
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Widens a channel of reduced depth by repeating its top bits.
    function automatic logic [7:0] widen(input logic [7:0] v, input int bits);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[7-i] = v[7 - (i % bits)];
        end
        return r;
    endfunction

    function automatic logic [23:0] colour_of(input pix_stage_t p, input logic lin);
        logic [23:0] rgb;
        rgb = 24'h000000;
        case (decode_mode(p.mode_code))
            MODE_TRUE24: rgb = {p.red, p.green, p.blue};
            MODE_TRUE15: rgb = {widen({p.red[4:0], 3'h0}, 5),
                    widen({p.green[4:0], 3'h0}, 5), widen({p.blue[4:0], 3'h0}, 5)};
            MODE_TRUE8: rgb = {widen({p.red[7:5], 5'h00}, 3),
                    widen({p.red[4:2], 5'h00}, 3), widen({p.red[1:0], 6'h00}, 2)};
            MODE_PSEUDO8: rgb = pal_mem[p.red];
            default: rgb = 24'h000000;
        endcase
        if (lin && decode_mode(p.mode_code) != MODE_PSEUDO8) begin
            rgb = {pal_mem[rgb[23:16]][23:16], pal_mem[rgb[15:8]][15:8],
                    pal_mem[rgb[7:0]][7:0]};
        end
        if (p.ovl != 4'h0) begin
            rgb = ovl_mem[4'(p.ovl - 4'h1)];
        end
        if (!p.blank_n) begin
            rgb = 24'h000000;
        end
        return rgb;
    endfunction

    function automatic logic [31:0] read_reg(input logic [`PP_ADDR_W-1:0] a,
            input state_t s, input logic [1:0] lvl);
        logic [31:0] r;
        r = 32'h00000000;
        case (a)
            `PP_OFF_CTRL: r[`PP_CTRL_LIN_BIT] = s.lin_en;
            `PP_OFF_PAL_ADDR: r[7:0] = s.pal_addr;
            `PP_OFF_PAL_DATA: r[23:0] = pal_mem[s.pal_addr];
            `PP_OFF_OVL_INDEX: r[3:0] = s.ovl_index;
            `PP_OFF_OVL_DATA: r[23:0] = ovl_mem[4'(s.ovl_index - 4'h1)];
            `PP_OFF_STATUS: begin
                r[`PP_ST_MODE_LSB +: 2] = s.s1.mode_code;
                r[`PP_ST_OVL_LSB +: 4] = s.s1.ovl;
                r[`PP_ST_BLANK_BIT] = s.s1.blank_n;
                r[`PP_ST_SYNC_BIT] = s.s1.sync_n;
                r[`PP_ST_LEVEL_LSB +: 2] = lvl;
            end
            default: r = 32'h00000000;
        endcase
        return r;
    endfunction

    function automatic logic reg_mapped(input logic [`PP_ADDR_W-1:0] a);
        case (a)
            `PP_OFF_CTRL, `PP_OFF_PAL_ADDR, `PP_OFF_PAL_DATA,
            `PP_OFF_OVL_INDEX, `PP_OFF_OVL_DATA, `PP_OFF_STATUS: reg_mapped = 1'b1;
            default: reg_mapped = 1'b0;
        endcase
    endfunction

    // The whole pipeline stalls together, so stages never slip against each other.
    assign advance = to_buf.ready;

    always_comb begin
        logic [31:0] merged;
        logic do_write;
        merged = 32'h00000000;
        do_write = 1'b0;
        d = q;
        pal_we = 1'b0;
        ovl_we = 1'b0;
        mem_wdata = 24'h000000;

        if (advance) begin
            d.s1 = '{valid: pix_valid, blank_n: blank_n, sync_n: sync_n,
                    mode_code: colour_mode_sel, ovl: overlay_sel,
                    red: red_pixel_in, green: green_pixel_in, blue: blue_pixel_in};
            d.s2 = q.s1;
            // pixel and overlay ignored when blanked
            d.s2_word = '{blank_n: q.s1.blank_n, sync_n: q.s1.sync_n,
                    rgb: colour_of(q.s1, q.lin_en)};
        end

        if (q.awready && s_axi_awvalid) begin
            d.awready = 1'b0;
            d.aw_got = 1'b1;
            d.waddr = {s_axi_awaddr[`PP_ADDR_W-1:2], 2'h0};
        end
        if (q.wready && s_axi_wvalid) begin
            d.wready = 1'b0;
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        do_write = q.aw_got && q.w_got && !q.bvalid;
        if (do_write) begin
            d.bvalid = 1'b1;
            d.bresp = reg_mapped(q.waddr) ? `PP_RESP_OKAY : `PP_RESP_SLVERR;
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            merged = merge_strb(read_reg(q.waddr, q, buf_level), q.wdata, q.wstrb);
            mem_wdata = merged[23:0];
            case (q.waddr)
                `PP_OFF_CTRL: d.lin_en = merged[`PP_CTRL_LIN_BIT];
                `PP_OFF_PAL_ADDR: d.pal_addr = merged[7:0];
                `PP_OFF_PAL_DATA: begin
                    pal_we = 1'b1;
                    d.pal_addr = q.pal_addr + 8'h01;
                end
                `PP_OFF_OVL_INDEX: begin
                    d.ovl_index = (merged[3:0] == 4'h0) ? 4'h1 : merged[3:0];
                end
                `PP_OFF_OVL_DATA: ovl_we = 1'b1;
                default: d.lin_en = q.lin_en;
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end

        if (q.arready && s_axi_arvalid) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rdata = read_reg({s_axi_araddr[`PP_ADDR_W-1:2], 2'h0}, q, buf_level);
            d.rresp = reg_mapped({s_axi_araddr[`PP_ADDR_W-1:2], 2'h0})
                    ? `PP_RESP_OKAY : `PP_RESP_SLVERR;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.lin_en <= `PP_CTRL_RESET;
            q.pal_addr <= `PP_PAL_ADDR_RESET;
            q.ovl_index <= `PP_OVL_INDEX_RESET;
            q.s1.blank_n <= 1'b0;
            q.s2.blank_n <= 1'b0;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Colour memories carry no reset; software loads them before use.
    always_ff @(posedge clk_sys) begin
        if (pal_we) begin
            pal_mem[q.pal_addr] <= mem_wdata;
        end
        if (ovl_we) begin
            ovl_mem[4'(q.ovl_index - 4'h1)] <= mem_wdata;
        end
    end

    assign to_buf.valid = q.s2.valid;
    assign to_buf.data = q.s2_word;
    assign from_buf.ready = dac_ready;

    pixel_out_buf #(.W(DAC_WORD_W)) u_out_buf (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_s(to_buf),
        .out_s(from_buf),
        .level(buf_level)
    );

    assign out_word = from_buf.data;
    assign pix_ready = to_buf.ready;
    assign dac_valid = from_buf.valid;
    assign dac_red = out_word.rgb[23:16];
    assign dac_green = out_word.rgb[15:8];
    assign dac_blue = out_word.rgb[7:0];
    assign dac_blank_n = out_word.blank_n;
    // sync current off when sync low
    assign sync_current_en = out_word.sync_n;

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

endmodule // pixel_port_blank_sync_latch

// >>> core/pixel_port_map.svh
// Register offsets, field positions and reset values of the pixel port block.
`ifndef PIXEL_PORT_MAP_SVH
`define PIXEL_PORT_MAP_SVH

`define PP_ADDR_W 6
`define PP_OFF_CTRL 6'h00
`define PP_OFF_PAL_ADDR 6'h04
`define PP_OFF_PAL_DATA 6'h08
`define PP_OFF_OVL_INDEX 6'h0C
`define PP_OFF_OVL_DATA 6'h10
`define PP_OFF_STATUS 6'h14

`define PP_CTRL_LIN_BIT 0
`define PP_CTRL_RESET 1'h0
`define PP_PAL_ADDR_RESET 8'h00
`define PP_OVL_INDEX_RESET 4'h1

`define PP_ST_MODE_LSB 0
`define PP_ST_OVL_LSB 4
`define PP_ST_BLANK_BIT 8
`define PP_ST_SYNC_BIT 9
`define PP_ST_LEVEL_LSB 12

`define PP_PAL_DEPTH 256
`define PP_OVL_DEPTH 15
`define PP_BUF_DEPTH 2
`define PP_MODE_MAP_DEFAULT 8'hE4

`define PP_RESP_OKAY 2'h0
`define PP_RESP_SLVERR 2'h2

`endif

// >>> core/pixel_port_pkg.sv
// Types shared by the pixel port block and its output buffer.
package pixel_port_pkg;

    // Colour modes, one-hot.
    typedef enum logic [3:0] {
        MODE_TRUE24 = 4'h1,
        MODE_TRUE15 = 4'h2,
        MODE_TRUE8 = 4'h4,
        MODE_PSEUDO8 = 4'h8
    } colour_mode_t;

    typedef struct packed {
        logic valid;
        logic blank_n;
        logic sync_n;
        logic [1:0] mode_code;
        logic [3:0] ovl;
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } pix_stage_t;

    // Word handed to the converters.
    typedef struct packed {
        logic blank_n;
        logic sync_n;
        logic [23:0] rgb;
    } dac_word_t;

    localparam int DAC_WORD_W = 26;

endpackage

// >>> core/pix_stream_if.sv
// Valid/ready stream carrying converter words between the pipeline and its buffer.
`timescale 1ns/1ps
interface pix_stream_if #(parameter int W = 26) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface // pix_stream_if

// >>> core/pixel_out_buf.sv
// Two-entry buffer in front of the converters, so a stalled receiver loses no word.
`timescale 1ns/1ps
`include "pixel_port_map.svh"
module pixel_out_buf
    import pixel_port_pkg::*;
#(
    parameter int W = 26
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    pix_stream_if.snk in_s,
    pix_stream_if.src out_s,
    output logic [1:0] level
);

    typedef struct packed {
        logic [W-1:0] e0;
        logic [W-1:0] e1;
        logic [1:0] cnt;
        logic in_rdy;
    } buf_state_t;

    buf_state_t q, d;
    logic push;
    logic pop;

    assign push = in_s.valid & q.in_rdy;
    assign pop = (q.cnt != 2'h0) & out_s.ready;

    always_comb begin
        d = q;
        if (pop) begin
            d.e0 = q.e1;
            d.cnt = q.cnt - 2'h1;
        end
        if (push) begin
            if (d.cnt == 2'h0) begin
                d.e0 = in_s.data;
            end else begin
                d.e1 = in_s.data;
            end
            d.cnt = d.cnt + 2'h1;
        end
        // Ready is registered, so it only admits a word when a slot is certainly free.
        d.in_rdy = (d.cnt != 2'(`PP_BUF_DEPTH));
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{e0: '0, e1: '0, cnt: 2'h0, in_rdy: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign in_s.ready = q.in_rdy;
    assign out_s.valid = (q.cnt != 2'h0);
    assign out_s.data = q.e0;
    assign level = q.cnt;

endmodule // pixel_out_buf

// >>> tb/pp_checker.sv
// Port checker of the pixel port: stream timing, stalls, blanking and bus handshakes.
`timescale 1ns/1ps
module pp_checker (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pix_valid,
    input wire logic pix_ready,
    input wire logic dac_valid,
    input wire logic dac_ready,
    input wire logic [7:0] dac_red,
    input wire logic [7:0] dac_green,
    input wire logic [7:0] dac_blue,
    input wire logic dac_blank_n,
    input wire logic sync_current_en,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    logic [25:0] word;
    assign word = {dac_blank_n, sync_current_en, dac_red, dac_green, dac_blue};
    logic aw_w;
    assign aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    property p_blank_zero;
        dac_valid && !dac_blank_n |-> word[23:0] == 24'h000000;
    endproperty
    a_blank_zero: assert property (p_blank_zero) else $error("blanked word not zero");
    property p_latency;
        pix_valid && pix_ready && dac_ready ##1 dac_ready [*2] |=> dac_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("word late");
    property p_stall_hold;
        dac_valid && !dac_ready |=> dac_valid && $stable(word);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("word lost in stall");
    // Stage pair and buffer drain well inside eight free cycles.
    property p_bubble;
        (!pix_valid && dac_ready) [*8] |=> !dac_valid;
    endproperty
    a_bubble: assert property (p_bubble) else $error("word without pixel");
    property p_wr_busy;
        aw_w |=> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write not held off");
    property p_wr_resp;
        aw_w |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write response repeated");
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read response late");

    c_blank: cover property (dac_valid && dac_ready && !dac_blank_n);
    c_full: cover property (pix_valid && !pix_ready);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // pp_checker

bind pixel_port_blank_sync_latch pp_checker u_chk (
    .clk_sys, .sys_rst, .pix_valid, .pix_ready, .dac_valid, .dac_ready, .dac_red,
    .dac_green, .dac_blue, .dac_blank_n, .sync_current_en, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid
);

// >>> tb/pixel_source.sv
// Graphics controller model: offers pixels and holds each until the port takes it.
`timescale 1ns/1ps
module pixel_source
    import pixel_port_pkg::*;
#(
    parameter bit SYNC_OFF = 1'b0
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic req,
    input wire pix_stage_t want,
    input wire logic pix_ready,
    output pix_stage_t pix
);
    pix_stage_t nxt;
    always_comb begin
        nxt = want;
        nxt.valid = 1'b1;
        if (want.blank_n) begin
            nxt.sync_n = 1'b1;
        end
        if (SYNC_OFF) begin
            nxt.sync_n = 1'b0;
        end
        if (want.mode_code[1]) begin
            nxt.green = 8'h00;
            nxt.blue = 8'h00;
        end
        // Idle lines toggle so a stale pixel can never pass for a fresh one.
        if (!req) begin
            nxt = ~pix;
            nxt.valid = 1'b0;
        end
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pix <= '0;
        end else if (!pix.valid || pix_ready) begin
            pix <= nxt;
        end
    end
endmodule // pixel_source

// >>> tb/tb_pixel_port_blank_sync_latch.sv
// Bench of the pixel port: registers, colour paths, blanking, sync and stalls.
`timescale 1ns/1ps
`include "pixel_port_map.svh"
module tb_pixel_port_blank_sync_latch
    import pixel_port_pkg::*;
();
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic dac_ready = 1'b1;
    logic run = 1'b0;
    logic stall = 1'b0;
    logic drain = 1'b0;
    logic lin = 1'b0;
    pix_stage_t want = '0;
    pix_stage_t px;
    pix_stage_t w;
    logic pix_ready, dac_valid, dac_blank_n, sync_current_en;
    logic [7:0] dac_red, dac_green, dac_blue;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [63:0] r64;
    logic [25:0] got;
    logic [23:0] pal [256];
    logic [23:0] ovm [16];
    logic [25:0] exp_q [$];
    int bad_count = 0;
    int compares = 0;
    int i;
    integer seed = 70;

    always #5 clk_sys = ~clk_sys;

    pixel_source src (.clk_sys, .sys_rst, .req(run), .want, .pix_ready, .pix(px));

    pixel_port_blank_sync_latch dut (
        .clk_sys, .sys_rst, .red_pixel_in(px.red), .green_pixel_in(px.green),
        .blue_pixel_in(px.blue), .colour_mode_sel(px.mode_code), .overlay_sel(px.ovl),
        .blank_n(px.blank_n), .sync_n(px.sync_n), .pix_valid(px.valid), .pix_ready,
        .dac_valid, .dac_ready, .dac_red, .dac_green, .dac_blue, .dac_blank_n,
        .sync_current_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic give_up();
        bad_count++;
        finish_test();
    endtask

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                @(posedge clk_sys);
                return;
            end
        end
        give_up();
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                @(posedge clk_sys);
                return;
            end
        end
        give_up();
    endtask

    function automatic logic [25:0] expect_word(input pix_stage_t p);
        logic [23:0] c;
        case (p.mode_code)
            2'h0: c = {p.red, p.green, p.blue};
            2'h1: c = {p.red[4:0], p.red[4:2], p.green[4:0], p.green[4:2],
                       p.blue[4:0], p.blue[4:2]};
            2'h2: c = {{2{p.red[7:5]}}, p.red[7:6], {2{p.red[4:2]}}, p.red[4:3], {4{p.red[1:0]}}};
            default: c = pal[p.red];
        endcase
        if (lin && p.mode_code != 2'h3) begin
            c = {pal[c[23:16]][23:16], pal[c[15:8]][15:8], pal[c[7:0]][7:0]};
        end
        if (p.ovl != 4'h0) c = ovm[p.ovl];
        if (!p.blank_n) c = 24'h000000;
        return {p.blank_n, p.sync_n, c};
    endfunction

    // Blanking and overlay are made rarer so every colour mode gets its share.
    always @(posedge clk_sys) begin
        r64 = {$random(seed), $random(seed)};
        w = r64[32:0];
        if (r64[40]) w.ovl = 4'h0;
        if (r64[41]) w.blank_n = 1'b1;
        want <= w;
        dac_ready <= drain | (!stall & (r64[42] | r64[43]));
    end

    always @(posedge clk_sys) begin
        if (!sys_rst && px.valid === 1'b1 && pix_ready === 1'b1) begin
            exp_q.push_back(expect_word(px));
        end
        if (!sys_rst && dac_valid === 1'b1 && dac_ready) begin
            got = {dac_blank_n, sync_current_en, dac_red, dac_green, dac_blue};
            if (exp_q.size() == 0) begin
                give_up();
            end else begin
                check("dac word", 32'(got), 32'(exp_q.pop_front()));
            end
        end
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        give_up();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        check("valid in reset", dac_valid, 1'b0);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        axi_rd(`PP_OFF_CTRL, rd, rs);
        check("ctrl reset", rd, 32'h00000000);
        axi_rd(`PP_OFF_OVL_INDEX, rd, rs);
        check("overlay index reset", rd, 32'h00000001);
        axi_wr(32'h00000018, 32'hFFFFFFFF, rs);
        check("unmapped write", rs, `PP_RESP_SLVERR);
        axi_rd(32'h00000018, rd, rs);
        check("unmapped read", {rd[29:0], rs}, {30'h0, `PP_RESP_SLVERR});
        axi_wr(`PP_OFF_PAL_ADDR, 32'h00000000, rs);
        for (i = 0; i < 256; i++) begin
            pal[i] = $random(seed);
            axi_wr(`PP_OFF_PAL_DATA, {8'h00, pal[i]}, rs);
        end
        for (i = 1; i < 16; i++) begin
            ovm[i] = $random(seed);
            axi_wr(`PP_OFF_OVL_INDEX, i, rs);
            axi_wr(`PP_OFF_OVL_DATA, {8'h00, ovm[i]}, rs);
        end
        axi_wr(`PP_OFF_PAL_ADDR, 32'h000000FF, rs);
        axi_rd(`PP_OFF_PAL_DATA, rd, rs);
        check("palette word", rd, {8'h00, pal[255]});
        run <= 1'b1;
        repeat (800) @(posedge clk_sys);
        stall <= 1'b1;
        repeat (12) @(posedge clk_sys);
        check("ready when full", pix_ready, 1'b0);
        stall <= 1'b0;
        drain <= 1'b1;
        run <= 1'b0;
        for (i = 0; i < 40 && exp_q.size() != 0; i++) begin
            @(posedge clk_sys);
        end
        check("words left", exp_q.size(), 32'h00000000);
        // Linearization is switched only while nothing is in flight.
        axi_wr(`PP_OFF_CTRL, 32'h00000001, rs);
        axi_rd(`PP_OFF_CTRL, rd, rs);
        check("ctrl lin", rd, 32'h00000001);
        lin = 1'b1;
        drain <= 1'b0;
        run <= 1'b1;
        repeat (300) @(posedge clk_sys);
        drain <= 1'b1;
        run <= 1'b0;
        for (i = 0; i < 40 && exp_q.size() != 0; i++) begin
            @(posedge clk_sys);
        end
        check("words left lin", exp_q.size(), 32'h00000000);
        finish_test();
    end
endmodule // tb_pixel_port_blank_sync_latch
